// ### src/swsel_defines.svh
/*
 Offsets, reset values, function codes and field positions of the switch
 output function select block. Assumes inclusion by bare name.
*/
`ifndef SWSEL_DEFINES_SVH
`define SWSEL_DEFINES_SVH

`define SWSEL_NUM_OUT        6
`define SWSEL_WORD_W         24
`define SWSEL_IDX_W          16
`define SWSEL_IDX_OUT1       16'h2410
`define SWSEL_IDX_OUT2       16'h2411
`define SWSEL_IDX_OUT3       16'h2412
`define SWSEL_IDX_OUT4       16'h2413
`define SWSEL_IDX_OUT5       16'h2414
`define SWSEL_IDX_OUT6       16'h2415

`define SWSEL_RST_OUT1       24'h00_0001
`define SWSEL_RST_OUT2       24'h00_0002
`define SWSEL_RST_OUT3       24'h00_0004
`define SWSEL_RST_OUT4       24'h00_0003
`define SWSEL_RST_OUT5       24'h00_0000
`define SWSEL_RST_OUT6       24'h00_0000

`define SWSEL_POL_BIT        7
`define SWSEL_CODE_LO_W      7
`define SWSEL_CODE_MASTER    7'h00
`define SWSEL_CODE_ALARM     7'h01
`define SWSEL_CODE_READY     7'h02
`define SWSEL_CODE_BRAKE     7'h03
`define SWSEL_CODE_INPOS     7'h04
`define SWSEL_CODE_ATSPD     7'h05
`define SWSEL_CODE_TLIM      7'h06
`define SWSEL_CODE_ZSPD      7'h07
`define SWSEL_CODE_VCOIN     7'h08
`define SWSEL_CODE_PCMD      7'h0B
`define SWSEL_CODE_VLIM      7'h0D
`define SWSEL_CODE_VCMD      7'h0F
`define SWSEL_CODE_SRVEN     7'h12
`define SWSEL_CODE_HOMED     7'h22

`define SWSEL_OUT_RESET      6'h3F
`define SWSEL_STATUS_TR_BIT  24

`endif

// ### src/swsel_pkg.sv
/*
 Types of the switch output function select block.
 Assumes swsel_defines.svh is on the include path.
*/
`include "swsel_defines.svh"

package swsel_pkg;

   typedef enum logic [1:0]
   {
      SWSEL_MODE_PP    = 2'b00,
      SWSEL_MODE_PV    = 2'b01,
      SWSEL_MODE_PT    = 2'b10,
      SWSEL_MODE_OTHER = 2'b11
   } swsel_mode_t;

   typedef logic [`SWSEL_WORD_W-1:0] swsel_word_t;

   typedef struct packed
   {
      logic                       pend;
      logic                       pend_err;
      logic [2:0]                 pend_sel;
      logic                       ack;
      logic                       err;
      swsel_word_t                rdata;
      logic [`SWSEL_NUM_OUT-1:0]  sw_out;
      logic                       target_reached;
   } swsel_state_t;

endpackage

// ### src/swsel_mem_if.sv
/*
 Interface between the select word store and the output logic.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`include "swsel_defines.svh"

interface swsel_mem_if;
   logic                                      wr;
   logic [2:0]                                wsel;
   logic [`SWSEL_WORD_W-1:0]                  wdata;
   logic [2:0]                                rsel;
   logic [`SWSEL_WORD_W-1:0]                  rdata;
   logic [`SWSEL_NUM_OUT*`SWSEL_WORD_W-1:0]   words;

   modport store (input wr, input wsel, input wdata, input rsel,
                  output rdata, output words);
   modport user  (output wr, output wsel, output wdata, output rsel,
                  input rdata, input words);
endinterface

// ### src/swsel_word_store.sv
/*
 Six select words with documented reset values and a registered read port.
 Assumes the caller only presents selects 0 to 5.
*/
`timescale 1ns/1ps
`include "swsel_defines.svh"

module swsel_word_store
   import swsel_pkg::*;
(
   input  wire logic    ref_clk,
   input  wire logic    rstn,
   swsel_mem_if.store   mem
);

   localparam logic [`SWSEL_NUM_OUT*`SWSEL_WORD_W-1:0] RST_WORDS =
      {`SWSEL_RST_OUT6, `SWSEL_RST_OUT5, `SWSEL_RST_OUT4,
       `SWSEL_RST_OUT3, `SWSEL_RST_OUT2, `SWSEL_RST_OUT1};

   logic [`SWSEL_NUM_OUT*`SWSEL_WORD_W-1:0] words;
   swsel_word_t                              rdata;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         words <= RST_WORDS;
         rdata <= 24'h00_0000;
      end
      else
      begin
         if (mem.wr)
         begin
            words[mem.wsel*`SWSEL_WORD_W +: `SWSEL_WORD_W] <= mem.wdata;
         end
         rdata <= words[mem.rsel*`SWSEL_WORD_W +: `SWSEL_WORD_W];
      end
   end

   assign mem.words = words;
   assign mem.rdata = rdata;

endmodule

// ### src/swsel_top.sv
/*
 Switch output function select: six select words pick which drive status
 flag, or its own master control bit, each switch output shows, and with
 which polarity. Also forms the target reached status bit.
 Assumes all inputs are synchronous to ref_clk; parameter accesses come
 from the object dictionary side as single-cycle strobes.
*/
`timescale 1ns/1ps
`include "swsel_defines.svh"

// Overview of operation
// - Base code drives output active low; code with bit 7 set drives active high.
// - Code 00h puts the output under master control, no inverted variant.
// - Master control drives outputs 1..6 from digital output object bits 0..5.
// - Codes 01h, 02h, 03h: alarm, servo ready, brake release; inverted 81h-83h.
// - Codes 04h, 05h, 06h: in position, at speed, torque limiting; 84h-86h.
// - Codes 07h, 08h: zero speed clamp, velocity coincidence; 87h, 88h.
// - Codes 0Bh, 0Dh, 0Fh: position cmd, speed limiting, speed cmd; inverted too.
// - Codes 12h, 22h: servo enabled, homing done; inverted 92h, A2h.
// - Target reached follows in-position, coincidence or torque limit by mode.
module swsel_top
   import swsel_pkg::*;
(
   input  wire logic                        ref_clk,
   input  wire logic                        rstn,
   input  wire logic                        param_wr,
   input  wire logic                        param_rd,
   input  wire logic [`SWSEL_IDX_W-1:0]     param_index,
   input  wire logic [`SWSEL_WORD_W-1:0]    param_wdata,
   output logic                             param_ack,
   output logic                             param_err,
   output logic [`SWSEL_WORD_W-1:0]         param_rdata,
   input  wire logic [`SWSEL_NUM_OUT-1:0]   master_out_bits,
   input  wire logic [1:0]                  control_mode,
   input  wire logic                        alarm_flag,
   input  wire logic                        servo_ready_flag,
   input  wire logic                        brake_release_flag,
   input  wire logic                        in_position_flag,
   input  wire logic                        speed_reached_flag,
   input  wire logic                        torque_limiting_flag,
   input  wire logic                        zero_speed_flag,
   input  wire logic                        velocity_coincidence_flag,
   input  wire logic                        position_command_flag,
   input  wire logic                        speed_limiting_flag,
   input  wire logic                        speed_command_flag,
   input  wire logic                        servo_enabled_flag,
   input  wire logic                        homing_done_flag,
   output logic [`SWSEL_NUM_OUT-1:0]        switch_out_1_to_6,
   output logic                             target_reached
);

   localparam int NUM_FLAGS = 13;

   swsel_mem_if                  mem ();
   swsel_state_t                 st;
   swsel_state_t                 next_st;
   logic                         hit;
   logic [2:0]                   sel;
   logic [NUM_FLAGS-1:0]         flag_vec;
   logic [`SWSEL_NUM_OUT-1:0]    lvl;

   swsel_word_store swsel_word_store_inst
   (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .mem     (mem)
   );

   // Bit order follows the function code table, lowest code first
   assign flag_vec =
   {
      homing_done_flag,
      servo_enabled_flag,
      speed_command_flag,
      speed_limiting_flag,
      position_command_flag,
      velocity_coincidence_flag,
      zero_speed_flag,
      torque_limiting_flag,
      speed_reached_flag,
      in_position_flag,
      brake_release_flag,
      servo_ready_flag,
      alarm_flag
   };

   // Maps an object index to a select word number
   function automatic logic [3:0] index_decode
   (
      input logic [`SWSEL_IDX_W-1:0]   idx
   );
      logic [`SWSEL_IDX_W-1:0] off;
      off = idx - `SWSEL_IDX_OUT1;
      if (idx >= `SWSEL_IDX_OUT1 && idx <= `SWSEL_IDX_OUT6)
         index_decode = {1'b1, off[2:0]};
      else
         index_decode = 4'h0;
   endfunction

   // Active state of the chosen flag; {master, flag}
   function automatic logic [1:0] code_flag
   (
      input logic [`SWSEL_CODE_LO_W-1:0]   code,
      input logic [NUM_FLAGS-1:0]          flg
   );
      code_flag = 2'b00;
      unique case (code)
         `SWSEL_CODE_MASTER: code_flag = 2'b10;
         `SWSEL_CODE_ALARM:  code_flag = {1'b0, flg[0]};
         `SWSEL_CODE_READY:  code_flag = {1'b0, flg[1]};
         `SWSEL_CODE_BRAKE:  code_flag = {1'b0, flg[2]};
         `SWSEL_CODE_INPOS:  code_flag = {1'b0, flg[3]};
         `SWSEL_CODE_ATSPD:  code_flag = {1'b0, flg[4]};
         `SWSEL_CODE_TLIM:   code_flag = {1'b0, flg[5]};
         `SWSEL_CODE_ZSPD:   code_flag = {1'b0, flg[6]};
         `SWSEL_CODE_VCOIN:  code_flag = {1'b0, flg[7]};
         `SWSEL_CODE_PCMD:   code_flag = {1'b0, flg[8]};
         `SWSEL_CODE_VLIM:   code_flag = {1'b0, flg[9]};
         `SWSEL_CODE_VCMD:   code_flag = {1'b0, flg[10]};
         `SWSEL_CODE_SRVEN:  code_flag = {1'b0, flg[11]};
         `SWSEL_CODE_HOMED:  code_flag = {1'b0, flg[12]};
         // Forbidden codes read as an inactive flag, never as master control
         default:            code_flag = 2'b00;
      endcase
   endfunction

   // Pin level of one output; flags passed in so callers see every change
   function automatic logic pin_level
   (
      input swsel_word_t                w,
      input logic                       mbit,
      input logic [NUM_FLAGS-1:0]       flg
   );
      logic [1:0] mf;
      // Code 00h only counts as master when all upper bits are zero
      if (w == 24'h00_0000)
         mf = 2'b10;
      else if (w[`SWSEL_WORD_W-1:`SWSEL_POL_BIT+1] != 16'h0000)
         mf = 2'b00;
      else
         mf = code_flag(w[`SWSEL_CODE_LO_W-1:0], flg);
      if (mf[1] && !w[`SWSEL_POL_BIT])
         pin_level = mbit;
      else if (mf[1])
         pin_level = 1'b1;
      else
         pin_level = w[`SWSEL_POL_BIT] ? mf[0] : !mf[0];
   endfunction

   // Target reached source for the active fieldbus mode
   function automatic logic mode_target
   (
      input swsel_mode_t   mode,
      input logic          inpos,
      input logic          vcoin,
      input logic          tlim
   );
      unique case (mode)
         SWSEL_MODE_PP:    mode_target = inpos;
         SWSEL_MODE_PV:    mode_target = vcoin;
         SWSEL_MODE_PT:    mode_target = tlim;
         SWSEL_MODE_OTHER: mode_target = 1'b0;
      endcase
   endfunction

   // One decoder per output, all six evaluated every clock
   generate
      for (genvar g = 0; g < `SWSEL_NUM_OUT; g++)
      begin : gen_out
         assign lvl[g] = pin_level(mem.words[g*`SWSEL_WORD_W +: `SWSEL_WORD_W],
                                   master_out_bits[g], flag_vec);
      end
   endgenerate

   always_comb
   begin
      logic [3:0]          dec;
      dec   = index_decode(param_index);
      hit   = dec[3];
      sel   = dec[2:0];

      mem.wr    = param_wr && hit;
      mem.wsel  = sel;
      mem.wdata = param_wdata;
      mem.rsel  = sel;

      next_st          = st;
      next_st.pend     = param_wr || param_rd;
      next_st.pend_err = !hit;
      next_st.pend_sel = sel;
      // Two-stage answer so read data comes from the store register
      next_st.ack      = st.pend;
      next_st.err      = st.pend && st.pend_err;
      if (st.pend)
         next_st.rdata = st.pend_err ? 24'h00_0000 : mem.rdata;

      next_st.sw_out = lvl;

      next_st.target_reached = mode_target(swsel_mode_t'(control_mode),
                                           in_position_flag,
                                           velocity_coincidence_flag,
                                           torque_limiting_flag);
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st        <= '0;
         st.sw_out <= `SWSEL_OUT_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign param_ack         = st.ack;
   assign param_err         = st.err;
   assign param_rdata       = st.rdata;
   assign switch_out_1_to_6 = st.sw_out;
   assign target_reached    = st.target_reached;

endmodule

// ### sim/swsel_sva.sv
/*
 Port checker for swsel_top: parameter answers and target reached.
 Assumes one clock, ref_clk, and an async active low rstn.
*/
`timescale 1ns/1ps
module swsel_sva
(
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic        param_wr,
   input wire logic        param_rd,
   input wire logic [15:0] param_index,
   input wire logic        param_ack,
   input wire logic        param_err,
   input wire logic [23:0] param_rdata,
   input wire logic [1:0]  control_mode,
   input wire logic        in_position_flag,
   input wire logic        velocity_coincidence_flag,
   input wire logic        torque_limiting_flag,
   input wire logic        target_reached
);
   logic up;
   wire  req = param_wr | param_rd;
   wire  hit = param_index >= 16'h2410 && param_index <= 16'h2415;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // First edge after release still shows reset values
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
         up <= 1'b0;
      else
         up <= 1'b1;
   AST_ACK_LAT: assert property (req |-> ##2 param_ack)
      else $error("no answer two cycles after request");
   AST_ACK_CAUSE: assert property (up && param_ack |-> $past(req, 2))
      else $error("answer without request");
   AST_ERR_ACK: assert property (param_err |-> param_ack)
      else $error("error flag without answer");
   AST_ERR_UNMAPPED: assert property (req && !hit |-> ##2 param_err && param_rdata == 24'h00_0000)
      else $error("unmapped index not refused");
   AST_ERR_MAPPED: assert property (req && hit |-> ##2 !param_err)
      else $error("mapped index refused");
   AST_TR_PP: assert property (up && $past(control_mode) == 2'b00 |->
      target_reached == $past(in_position_flag))
      else $error("target reached wrong in position mode");
   AST_TR_PV: assert property (up && $past(control_mode) == 2'b01 |->
      target_reached == $past(velocity_coincidence_flag))
      else $error("target reached wrong in velocity mode");
   AST_TR_PT: assert property (up && $past(control_mode) == 2'b10 |->
      target_reached == $past(torque_limiting_flag))
      else $error("target reached wrong in torque mode");
   cover property (param_err);
   cover property (target_reached);
   cover property (up && control_mode == 2'b11);
endmodule
bind swsel_top swsel_sva swsel_sva_inst
(
   .ref_clk                   (ref_clk),
   .rstn                      (rstn),
   .param_wr                  (param_wr),
   .param_rd                  (param_rd),
   .param_index               (param_index),
   .param_ack                 (param_ack),
   .param_err                 (param_err),
   .param_rdata               (param_rdata),
   .control_mode              (control_mode),
   .in_position_flag          (in_position_flag),
   .velocity_coincidence_flag (velocity_coincidence_flag),
   .torque_limiting_flag      (torque_limiting_flag),
   .target_reached            (target_reached)
);

// ### sim/swsel_load.sv
/*
 External loads on the six switch outputs, relay coils or controller inputs.
 Assumes open-collector outputs that sink current when driven low.
*/
`timescale 1ns/1ps
module swsel_load
(
   input  wire logic [5:0] pin,
   output logic      [5:0] energised
);
   // Coil pulls in only while the output transistor conducts
   assign energised = ~pin;
endmodule

// ### sim/swsel_top_bench.sv
/*
 Self-checking bench for swsel_top: select words, decode, master control.
 Assumes design, checker and load model are compiled before it.
*/
`timescale 1ns/1ps
`include "swsel_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module swsel_top_bench
   import swsel_pkg::*;
;
   logic        ref_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ack, err, tr;
   logic [15:0] idx = 16'h2410;
   logic [23:0] wd = 24'h00_0000, rdat;
   logic [5:0]  mb = 6'h00, sw, en;
   logic [1:0]  md = 2'b00;
   logic [12:0] fl = 13'h0000;
   int          miscompares = 0, n_tests = 0, cyc = 0;
   logic [7:0]  codes [13] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                               8'h08, 8'h0B, 8'h0D, 8'h0F, 8'h12, 8'h22};
   logic [23:0] rv [6] = '{24'h00_0001, 24'h00_0002, 24'h00_0004, 24'h00_0003,
                           24'h00_0000, 24'h00_0000};
   swsel_top swsel_top_inst
   (
      .ref_clk(ref_clk), .rstn(rstn), .param_wr(wr), .param_rd(rd), .param_index(idx),
      .param_wdata(wd), .param_ack(ack), .param_err(err), .param_rdata(rdat),
      .master_out_bits(mb), .control_mode(md), .alarm_flag(fl[0]), .servo_ready_flag(fl[1]),
      .brake_release_flag(fl[2]), .in_position_flag(fl[3]), .speed_reached_flag(fl[4]),
      .torque_limiting_flag(fl[5]), .zero_speed_flag(fl[6]),
      .velocity_coincidence_flag(fl[7]), .position_command_flag(fl[8]),
      .speed_limiting_flag(fl[9]), .speed_command_flag(fl[10]),
      .servo_enabled_flag(fl[11]), .homing_done_flag(fl[12]),
      .switch_out_1_to_6(sw), .target_reached(tr)
   );
   swsel_load swsel_load_inst (.pin(sw), .energised(en));
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         miscompares++;
         complete_run();
      end
   end
   task complete_run;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Answer stands one cycle; read it before the second edge after the taken one
   task acc(input logic w, input logic [15:0] i, input logic [23:0] d);
      @(posedge ref_clk);
      wr <= w;
      rd <= !w;
      idx <= i;
      wd <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge ref_clk);
      #1;
      `CHK(ack, 1'b1)
   endtask
   task t_regs;
      `CHK(sw, 6'h0F)
      for (int i = 0; i < 6; i++)
      begin
         acc(1'b0, 16'h2410 + i[15:0], 24'h00_0000);
         `CHK(rdat, rv[i])
      end
      acc(1'b1, 16'h2415, 24'h00_00A2);
      acc(1'b0, 16'h2415, 24'h00_0000);
      `CHK(rdat, 24'h00_00A2)
      acc(1'b1, 16'h2416, 24'h00_0012);
      `CHK(err, 1'b1)
      acc(1'b0, 16'h2416, 24'h00_0000);
      `CHK({err, rdat}, {1'b1, 24'h00_0000})
   endtask
   task t_codes;
      for (int j = 0; j < 13; j++)
      begin
         @(posedge ref_clk);
         fl <= 13'h0001 << j;
         acc(1'b1, 16'h2411, {16'h0000, codes[j]});
         `CHK(sw[1], 1'b0)
         acc(1'b1, 16'h2411, {16'h0000, codes[j] | 8'h80});
         `CHK(sw[1], 1'b1)
         @(posedge ref_clk);
         fl <= 13'h0000;
         @(posedge ref_clk);
         #1;
         `CHK(sw[1], 1'b0)
      end
   endtask
   task t_master;
      for (int i = 0; i < 6; i++)
         acc(1'b1, 16'h2410 + i[15:0], 24'h00_0000);
      for (int p = 0; p < 2; p++)
      begin
         @(posedge ref_clk);
         mb <= p ? 6'h2A : 6'h15;
         @(posedge ref_clk);
         #1;
         `CHK(sw, p ? 6'h2A : 6'h15)
         `CHK(en, p ? 6'h15 : 6'h2A)
      end
      // Neither value is master control despite a zero 7-bit code field
      acc(1'b1, 16'h2410, 24'h00_0080);
      `CHK(sw[0], 1'b1)
      acc(1'b1, 16'h2410, 24'h01_0000);
      `CHK(sw[0], 1'b1)
   endtask
   task t_target;
      int sel [3] = '{3, 7, 5};
      for (int m = 0; m < 4; m++)
         for (int f = 0; f < 3; f++)
         begin
            @(posedge ref_clk);
            md <= m[1:0];
            fl <= 13'h0001 << sel[f];
            @(posedge ref_clk);
            #1;
            `CHK(tr, m < 3 && f == m)
         end
   endtask
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      #1;
      t_regs();
      t_codes();
      t_master();
      t_target();
      complete_run();
   end
endmodule
